// File: logic/table_access_params.svh
// Constants for the table access unit: opcode patterns, reset values, widths.
// Assumes inclusion by bare name from the package and the design module.
`ifndef TABLE_ACCESS_PARAMS_SVH
`define TABLE_ACCESS_PARAMS_SVH
`define TA_PTR_W        21
`define TA_DATA_W       8
`define TA_OP_W         16
`define TA_HOLD_SEL_W   3
`define TA_HOLD_N       8
`define TA_READ_OP      16'h0008
`define TA_WRITE_OP     16'h000C
`define TA_OP_MASK      16'hFFFC
`define TA_MODE_MSB     1
`define TA_PTR_RESET    21'h00_0000
`define TA_LATCH_RESET  8'h00
`define TA_PTR_ONE      21'h00_0001
`define TA_BYTE_SEL_BIT 0
`endif

// File: logic/table_access_pkg.sv
// Types for the table access unit.
// Assumes table_access_params.svh is on the include path.
`include "table_access_params.svh"
package table_access_pkg;
    typedef enum logic [1:0] {
        PTR_KEEP,
        PTR_POST_INC,
        PTR_POST_DEC,
        PTR_PRE_INC
    } ptr_mode_t;
    typedef enum logic [2:0] {
        PH_Q1,
        PH_Q2,
        PH_Q3,
        PH_Q4
    } phase_t;
endpackage

// File: logic/table_access_unit.sv
// Table read and table write execution logic of a core.
// Assumes q-phase strobes from the core sequencer, one of q1..q4 per clock,
// an opcode presented with q1 of an instruction's first cycle, and program
// memory data valid by q4 of the second cycle.
//
// Notes on behaviour
// - Write mode 0 stores latch, pointer unchanged.
// - Write post-increment: store, then pointer plus one.
// - Write post-decrement: store, then pointer minus one.
// - Write pre-increment: bump pointer, then store.
// - Decode write opcode; low two bits give mode.
// - Pointer low three bits pick holding register.
// - Table write touches no status flags.
// - Read cycle one decodes in q1, otherwise idle.
// - Read cycle two: memory read q2, latch q4.
// - Memory read strobe separate from latch update.
// - Read post-increment: old address, pointer plus one.
// - Read pre-increment: bump first, read new address.
// - Pointer is 21-bit byte address, 2 Mbyte.
// - Pointer bit zero picks low or high byte.
`timescale 1ns/1ns
`include "table_access_params.svh"
module table_access_unit #(
    parameter int PTR_W  = `TA_PTR_W,
    parameter int DATA_W = `TA_DATA_W,
    parameter int HOLD_N = `TA_HOLD_N
) (
    input  wire logic                 clk_i,         // Core clock, 250 MHz
    input  wire logic                 rst_n_i,       // Async reset, active low
    input  wire logic                 q1_i,          // Phase q1 strobe
    input  wire logic                 q2_i,          // Phase q2 strobe
    input  wire logic                 q4_i,          // Phase q4 strobe
    input  wire logic                 op_valid_i,    // Opcode presented this q1
    input  wire logic [`TA_OP_W-1:0]  opcode_i,      // Instruction word
    input  wire logic [DATA_W-1:0]    mem_rdata_i,   // Program memory word byte
    input  wire logic                 ptr_load_i,    // Software loads pointer
    input  wire logic [PTR_W-1:0]     ptr_wdata_i,   // Pointer load value
    input  wire logic                 latch_load_i,  // Software loads latch
    input  wire logic [DATA_W-1:0]    latch_wdata_i, // Latch load value
    output logic      [PTR_W-1:0]     byte_pointer_o,   // Table pointer
    output logic      [DATA_W-1:0]    transfer_latch_o, // Table latch
    output logic                      mem_rd_o,         // Memory read, one cycle
    output logic      [PTR_W-1:0]     mem_addr_o,       // Byte address read
    output logic                      hi_byte_o,        // High byte selected
    output logic      [HOLD_N*DATA_W-1:0] holding_o,    // Holding registers
    output logic                      busy_o            // Second cycle active
);
    localparam int SEL_W = $clog2(HOLD_N);

    logic [PTR_W-1:0]          byte_pointer;
    logic [PTR_W-1:0]          next_byte_pointer;
    logic [DATA_W-1:0]         transfer_latch;
    logic [DATA_W-1:0]         next_transfer_latch;
    logic [DATA_W-1:0]         hold [HOLD_N];
    logic                      mem_rd;
    logic                      next_mem_rd;
    logic [PTR_W-1:0]          mem_addr;
    logic [PTR_W-1:0]          next_mem_addr;
    logic                      in_second;
    logic                      next_in_second;
    logic                      is_write;
    logic                      next_is_write;
    table_access_pkg::ptr_mode_t mode;
    table_access_pkg::ptr_mode_t next_mode;

    logic                      dec_read;
    logic                      dec_write;
    logic [PTR_W-1:0]          ptr_inc;
    logic [PTR_W-1:0]          ptr_dec;
    logic [PTR_W-1:0]          ptr_use;
    logic [SEL_W-1:0]          sel;
    logic                      op_take;
    logic                      rd_step;
    logic                      end_step;

    // Q1 decode only; q2..q4 of the first cycle do nothing
    assign dec_read  = q1_i && op_valid_i
                     && ((opcode_i & `TA_OP_MASK) == `TA_READ_OP);
    assign dec_write = q1_i && op_valid_i
                     && ((opcode_i & `TA_OP_MASK) == `TA_WRITE_OP);

    // Wraps naturally at the pointer width
    assign ptr_inc = byte_pointer + PTR_W'(`TA_PTR_ONE);
    assign ptr_dec = byte_pointer - PTR_W'(`TA_PTR_ONE);
    // Pre-increment works on the advanced pointer
    assign ptr_use = (mode == table_access_pkg::PTR_PRE_INC) ? ptr_inc : byte_pointer;
    assign sel     = ptr_use[SEL_W-1:0];

    // A new opcode while an op runs is ignored, not queued
    assign op_take  = !in_second && (dec_read || dec_write);
    // Read strobe in q2, kept apart from the q4 latch load
    assign rd_step  = in_second && q2_i && !is_write;
    // Q2 read step takes priority should q2 and q4 ever coincide
    assign end_step = in_second && q4_i && !rd_step;

    // Sequencing: mode and write flag are captured at decode and held
    always_comb begin
        next_in_second = in_second;
        next_is_write  = is_write;
        next_mode      = mode;
        if (op_take) begin
            // Mode field is the lowest two opcode bits
            next_mode      = table_access_pkg::ptr_mode_t'(opcode_i[`TA_MODE_MSB:0]);
            next_is_write  = dec_write;
            next_in_second = 1'b1;
        end else if (end_step) begin
            next_in_second = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            in_second <= 1'b0;
            is_write  <= 1'b0;
            mode      <= table_access_pkg::PTR_KEEP;
        end else begin
            in_second <= next_in_second;
            is_write  <= next_is_write;
            mode      <= next_mode;
        end
    end

    // Pointer: a software load in the op's final q4 loses to the op
    always_comb begin
        next_byte_pointer = byte_pointer;
        if (ptr_load_i) begin
            next_byte_pointer = ptr_wdata_i;
        end
        if (end_step) begin
            unique case (mode)
                table_access_pkg::PTR_KEEP: begin
                    next_byte_pointer = byte_pointer;
                end
                table_access_pkg::PTR_POST_INC: begin
                    next_byte_pointer = ptr_inc;
                end
                table_access_pkg::PTR_POST_DEC: begin
                    next_byte_pointer = ptr_dec;
                end
                table_access_pkg::PTR_PRE_INC: begin
                    next_byte_pointer = ptr_inc;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            byte_pointer <= `TA_PTR_RESET;
        end else begin
            byte_pointer <= next_byte_pointer;
        end
    end

    // Latch: filled from memory only at the end of a read
    always_comb begin
        next_transfer_latch = transfer_latch;
        if (latch_load_i) begin
            next_transfer_latch = latch_wdata_i;
        end
        if (end_step && !is_write) begin
            next_transfer_latch = mem_rdata_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            transfer_latch <= `TA_LATCH_RESET;
        end else begin
            transfer_latch <= next_transfer_latch;
        end
    end

    // Memory read port: strobe lasts one cycle, address holds after it
    always_comb begin
        next_mem_rd   = 1'b0;
        next_mem_addr = mem_addr;
        if (rd_step) begin
            next_mem_rd   = 1'b1;
            next_mem_addr = ptr_use;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mem_rd   <= 1'b0;
            mem_addr <= `TA_PTR_RESET;
        end else begin
            mem_rd   <= next_mem_rd;
            mem_addr <= next_mem_addr;
        end
    end

    assign byte_pointer_o   = byte_pointer;
    assign transfer_latch_o = transfer_latch;
    assign mem_rd_o         = mem_rd;
    assign mem_addr_o       = mem_addr;
    // Byte lane of the program word
    assign hi_byte_o        = mem_addr[`TA_BYTE_SEL_BIT];
    assign busy_o           = in_second;

    // Holding registers: one flop group each, only the selected one moves
    genvar g;
    generate
        for (g = 0; g < HOLD_N; g++) begin : g_hold
            logic [DATA_W-1:0] next_hold_g;

            always_comb begin
                next_hold_g = hold[g];
                // Only holding register and pointer change, no flags
                if (end_step && is_write && (sel == SEL_W'(g))) begin
                    next_hold_g = transfer_latch;
                end
            end

            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    hold[g] <= `TA_LATCH_RESET;
                end else begin
                    hold[g] <= next_hold_g;
                end
            end

            assign holding_o[g*DATA_W +: DATA_W] = hold[g];
        end
    endgenerate
endmodule

// File: sim/prog_mem_model.sv
// Program memory stand-in; byte content derived from the byte address.
// Assumes one read strobe per table read; data is held one cycle only.
`timescale 1ns/1ns
module prog_mem_model (
    input  wire logic        clk_i,  // Core clock
    input  wire logic        rd_i,   // Read strobe
    input  wire logic [20:0] addr_i, // Byte address
    output logic      [7:0]  data_o  // Byte read
);
    initial data_o = 8'h00;
    always @(posedge clk_i) begin
        if (rd_i) begin
            data_o <= addr_i[7:0] ^ addr_i[15:8] ^ 8'h5a;
        end else begin
            data_o <= ~data_o; // Stale byte flips so it never passes
        end
    end
endmodule

// File: sim/table_access_unit_assertions.sv
// Port checker for the table access unit.
// Assumes q1..q4 strobes on successive clocks and no loads during an op.
`timescale 1ns/1ns
module table_access_checker (
    input wire logic        clk_i,            // Core clock
    input wire logic        rst_n_i,          // Async reset
    input wire logic        q1_i,             // Phase q1
    input wire logic        op_valid_i,       // Opcode valid
    input wire logic [15:0] opcode_i,         // Instruction
    input wire logic [7:0]  mem_rdata_i,      // Memory byte
    input wire logic [20:0] byte_pointer_o,   // Pointer
    input wire logic [7:0]  transfer_latch_o, // Latch
    input wire logic        mem_rd_o,         // Read strobe
    input wire logic [20:0] mem_addr_o,       // Read address
    input wire logic        hi_byte_o,        // Byte select
    input wire logic        busy_o            // Second cycle
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    wire logic take = q1_i && op_valid_i && !busy_o;
    property p_rd_one; mem_rd_o |=> !mem_rd_o; endproperty
    a_rd_one: assert property (p_rd_one) else $error("read strobe too long");
    property p_hi; mem_rd_o |-> hi_byte_o == mem_addr_o[0]; endproperty
    a_hi: assert property (p_hi) else $error("byte select wrong");
    property p_busy; $rose(busy_o) |-> busy_o [*3] ##1 !busy_o; endproperty
    a_busy: assert property (p_busy) else $error("op length wrong");
    property p_rd_addr; take && opcode_i inside {16'h0008, 16'h0009, 16'h000a}
        |-> ##2 mem_rd_o && mem_addr_o == $past(byte_pointer_o, 2); endproperty
    a_rd_addr: assert property (p_rd_addr) else $error("read address wrong");
    property p_rd_pre; take && opcode_i == 16'h000b
        |-> ##2 mem_rd_o && mem_addr_o == 21'($past(byte_pointer_o, 2) + 1); endproperty
    a_rd_pre: assert property (p_rd_pre) else $error("pre-increment address wrong");
    property p_latch; mem_rd_o |-> ##2 transfer_latch_o == $past(mem_rdata_i); endproperty
    a_latch: assert property (p_latch) else $error("latch not loaded");
    property p_wr_keep; take && opcode_i == 16'h000c
        |-> ##4 byte_pointer_o == $past(byte_pointer_o, 4); endproperty
    a_wr_keep: assert property (p_wr_keep) else $error("pointer moved");
    property p_wr_inc; take && opcode_i == 16'h000d
        |-> ##4 byte_pointer_o == 21'($past(byte_pointer_o, 4) + 1); endproperty
    a_wr_inc: assert property (p_wr_inc) else $error("pointer not incremented");
    property p_wr_dec; take && opcode_i == 16'h000e
        |-> ##4 byte_pointer_o == 21'($past(byte_pointer_o, 4) - 1); endproperty
    a_wr_dec: assert property (p_wr_dec) else $error("pointer not decremented");
    property p_wr_nord; take && opcode_i[15:2] == 14'h0003 |=> !mem_rd_o [*3]; endproperty
    a_wr_nord: assert property (p_wr_nord) else $error("write read memory");
endmodule
bind table_access_unit table_access_checker u_chk (.clk_i, .rst_n_i, .q1_i, .op_valid_i,
    .opcode_i, .mem_rdata_i, .byte_pointer_o, .transfer_latch_o, .mem_rd_o, .mem_addr_o,
    .hi_byte_o, .busy_o);

// File: sim/test_table_access_unit.sv
// Self-checking bench for the table access unit with a memory model.
// Assumes strobes q1..q4 on successive clocks, one op per frame.
`timescale 1ns/1ns
module test_table_access_unit;
    logic        clk_i, rst_n_i, q1_i, q2_i, q4_i, op_valid_i, ptr_load_i, latch_load_i;
    logic        mem_rd_o, hi_byte_o, busy_o, busy_d;
    logic [15:0] opcode_i;
    logic [7:0]  mem_rdata_i, latch_wdata_i, transfer_latch_o, lat;
    logic [20:0] ptr_wdata_i, byte_pointer_o, mem_addr_o, ptr;
    logic [63:0] holding_o, hold;
    logic [92:0] notes[$];
    int          mismatches = 0, n_checks = 0, seed = 91;
    table_access_unit uut (.clk_i, .rst_n_i, .q1_i, .q2_i, .q4_i, .op_valid_i, .opcode_i,
        .mem_rdata_i, .ptr_load_i, .ptr_wdata_i, .latch_load_i, .latch_wdata_i,
        .byte_pointer_o, .transfer_latch_o, .mem_rd_o, .mem_addr_o, .hi_byte_o,
        .holding_o, .busy_o);
    prog_mem_model u_mem (.clk_i, .rd_i(mem_rd_o), .addr_i(mem_addr_o), .data_o(mem_rdata_i));
    initial begin
        clk_i = 0;
        forever #2 clk_i = ~clk_i;
    end
    task automatic check(input string nm, input logic [92:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic frame(input logic v, input logic [15:0] op, input logic ld);
        {q1_i, op_valid_i, ptr_load_i, latch_load_i} = {1'b1, v, ld, ld};
        opcode_i = op;
        @(posedge clk_i) #1 {q1_i, op_valid_i, ptr_load_i, latch_load_i, q2_i} = 5'h01;
        @(posedge clk_i) #1 q2_i = 0;
        @(posedge clk_i) #1 q4_i = 1;
        @(posedge clk_i) #1 q4_i = 0;
    endtask
    task automatic load(input logic [20:0] p, input logic [7:0] l);
        {ptr_wdata_i, ptr, latch_wdata_i, lat} = {p, p, l, l};
        frame(1'b0, 16'h0000, 1'b1);
    endtask
    task automatic run(input logic [15:0] op);
        if (op[1:0] == 2'h3) ptr = ptr + 21'h00_0001;
        if (op[2]) hold[ptr[2:0]*8 +: 8] = lat;
        else lat = ptr[7:0] ^ ptr[15:8] ^ 8'h5a;
        if (op[1:0] == 2'h1) ptr = ptr + 21'h00_0001;
        if (op[1:0] == 2'h2) ptr = ptr - 21'h00_0001;
        notes.push_back({ptr, lat, hold});
        frame(1'b1, op, 1'b0);
    endtask
    always @(negedge clk_i) begin
        if (busy_d && !busy_o) begin
            if (notes.size() == 0) check("extra result", 93'h1, 93'h0);
            else check("result", {byte_pointer_o, transfer_latch_o, holding_o}, notes.pop_front());
        end
        busy_d = busy_o;
    end
    initial begin
        {q1_i, q2_i, q4_i, op_valid_i, ptr_load_i, latch_load_i, rst_n_i, busy_d} = 8'h00;
        {opcode_i, ptr_wdata_i, latch_wdata_i, ptr, lat, hold} = 138'h0;
        repeat (6) @(posedge clk_i);
        #1 rst_n_i = 1;
        check("reset", {byte_pointer_o, transfer_latch_o, holding_o}, 93'h0);
        for (int i = 0; i < 24; i++) begin
            load(21'($random(seed)), 8'($random(seed)));
            run(16'h0008 + 16'(i % 8));
        end
        load(21'h1f_ffff, 8'ha5);
        run(16'h000d);
        run(16'h000b);
        load(21'h00_0000, 8'h3c);
        run(16'h000e);
        run(16'h000a);
        frame(1'b1, 16'h0010, 1'b0);
        check("ignored", {byte_pointer_o, transfer_latch_o, holding_o}, {ptr, lat, hold});
        check("pending", 93'(notes.size()), 93'h0);
        end_of_test();
    end
endmodule
